// ### verilog/usp_pkg.sv
// Constants shared by the serial port control block
package usp_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTL_ADDR = 8'h98;
    localparam logic [7:0] DATA_ADDR = 8'h99;
    localparam logic [3:0] SFR_PAGE = 4'h0;
    localparam logic [7:0] CTL_RESET = 8'h40;
    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int FRAME_WIDTH_POS = 7;
    localparam int FIXED_ONE_POS = 6;
    localparam int ADDR_FILTER_POS = 5;
    localparam int RX_ENABLE_POS = 4;
    localparam int TX_NINTH_POS = 3;
    localparam int RX_NINTH_POS = 2;
    localparam int TX_DONE_POS = 1;
    localparam int RX_DONE_POS = 0;
    // ------------------------------------------------------------
    // Frame and buffer sizes
    // ------------------------------------------------------------
    localparam int DATA_BITS = 8;
    localparam int TX_FIFO_DEPTH = 4;
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;
endpackage

// ### verilog/usp_fifo.sv
// Small transmit FIFO with registered read data
`timescale 1ns/1ps
module usp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    // Refused at elaboration, the pointer wrap needs two slots
    if (DEPTH < 2 || WIDTH < 1) begin : gBadSize
        $error("usp_fifo: DEPTH must be at least 2 and WIDTH at least 1");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [CW-1:0] count_reg;

    wire push = inValid & inReady;
    wire pop = outValid & outReady;
    assign inReady = (count_reg != CW'(DEPTH));
    assign outValid = (count_reg != '0);

    // ------------------------------------------------------------
    // Pointers and fill level
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wrPtr_reg <= (wrPtr_reg == LAST) ? '0 : wrPtr_reg + 1'b1;
            end
            if (pop) begin
                rdPtr_reg <= (rdPtr_reg == LAST) ? '0 : rdPtr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    // Storage; popped word appears on outData one cycle after pop
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            outData <= '0;
        end else if (pop) begin
            outData <= mem[rdPtr_reg];
        end
    end
endmodule

// ### verilog/usp_serial_port.sv
// Serial port control and status logic with transmit and receive framing
// Notes on behaviour
// - Control bit 7 picks 8-bit frame at 0, 9-bit frame at 1.
// - Control bit 6 always reads one; writing it does nothing.
// - 8-bit mode with filter set: receive-done only when stop bit is one.
// - 9-bit mode with filter (bit 5) set: accept only if ninth bit one.
// - Receive enable bit 4 gates start detection; at zero no new frame starts.
// - 9-bit mode sends the transmit ninth bit (bit 3) as ninth bit.
// - Accepted frame loads bit 2 with stop bit or ninth bit per mode.
// - Transmit-done (bit 1) sets at the start of the stop bit.
// - Transmit-done requests the interrupt; only software clears it.
// - Receive-done (bit 0) sets at stop-bit sampling of accepted frame.
// - Receive-done requests the interrupt; only software clears it.
// - Control register sits at 0x98 page 0, every bit bit-addressable.
// - 8-bit frame: start, eight data bits LSB first, stop.
// - 9-bit frame adds programmable ninth bit; received stop ignored.
// - Store a frame only if receive-done is clear and filter passes.
// - Writing the data buffer queues that byte for a transmit frame; a write while the FIFO is full is dropped.
`timescale 1ns/1ps
module usp_serial_port #(
    parameter int FIFO_DEPTH = usp_pkg::TX_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] sfrAddr,
    input wire logic [3:0] sfrPage,
    input wire logic sfrWr,
    input wire logic sfrRd,
    input wire logic [7:0] sfrWrData,
    output logic [7:0] sfrRdData,
    input wire logic bitWr,
    input wire logic [7:0] bitAddr,
    input wire logic bitWrData,
    input wire logic timerOverflow,
    input wire logic intEnable,
    output logic intRequest,
    output logic txReady,
    input wire logic rxPin,
    output logic txPin
);
    typedef enum logic [2:0] {
        TX_IDLE, TX_LOAD, TX_START, TX_DATA, TX_NINTH, TX_STOP
    } usp_tx_e;
    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP
    } usp_rx_e;

    if (FIFO_DEPTH < 2) begin : gBadDepth
        $error("usp_serial_port: FIFO_DEPTH must be at least 2");
    end

    // ------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rstSync_reg;
    logic rxMeta_reg;
    logic rxPinS_reg;
    logic rxPrev_reg;
    wire rstn = rstSync_reg[1];

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rstSync_reg <= 2'h0;
        end else begin
            rstSync_reg <= {rstSync_reg[0], 1'b1};
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rxMeta_reg <= 1'b1;
            rxPinS_reg <= 1'b1;
            rxPrev_reg <= 1'b1;
        end else begin
            rxMeta_reg <= rxPin;
            rxPinS_reg <= rxMeta_reg;
            rxPrev_reg <= rxPinS_reg;
        end
    end

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    function automatic logic sfrHit(input logic [7:0] a, input logic [3:0] p,
                                    input logic [7:0] target);
        return (a == target) && (p == usp_pkg::SFR_PAGE);
    endfunction

    function automatic logic pick(input logic cur, input logic m,
                                  input logic v);
        return m ? v : cur;
    endfunction

    wire ctlByteWr = sfrWr & sfrHit(sfrAddr, sfrPage, usp_pkg::CTL_ADDR);
    wire ctlBitWr = bitWr & sfrHit({bitAddr[7:3], 3'h0}, sfrPage,
                                   usp_pkg::CTL_ADDR);
    wire dataWr = sfrWr & sfrHit(sfrAddr, sfrPage, usp_pkg::DATA_ADDR);
    wire ctlRd = sfrRd & sfrHit(sfrAddr, sfrPage, usp_pkg::CTL_ADDR);
    wire dataRd = sfrRd & sfrHit(sfrAddr, sfrPage, usp_pkg::DATA_ADDR);
    wire ctlWrAny = ctlByteWr | ctlBitWr;
    wire [7:0] bitSel = 8'h01 << bitAddr[2:0];
    wire [7:0] wrMask = ctlByteWr ? 8'hFF : (ctlBitWr ? bitSel : 8'h00);
    wire [7:0] wrVal = ctlByteWr ? sfrWrData : {8{bitWrData}};

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    logic modeReg_reg;
    logic filterEn_reg;
    logic rxEnable_reg;
    logic txNinth_reg;
    logic rxNinth_reg;
    logic txDone_reg;
    logic rxDone_reg;
    logic [7:0] rxLatch_reg;
    logic rxAccept;
    logic rxNinthVal;
    logic txEnterStop;
    logic [7:0] rxShift_reg;

    wire [7:0] ctlValue = {modeReg_reg, 1'b1, filterEn_reg, rxEnable_reg,
                           txNinth_reg, rxNinth_reg, txDone_reg,
                           rxDone_reg};

    // Hardware set wins over a software clear in the same cycle
    wire txDoneNext = txEnterStop |
        pick(txDone_reg, wrMask[usp_pkg::TX_DONE_POS],
             wrVal[usp_pkg::TX_DONE_POS]);
    wire rxDoneNext = rxAccept |
        pick(rxDone_reg, wrMask[usp_pkg::RX_DONE_POS],
             wrVal[usp_pkg::RX_DONE_POS]);
    wire rxNinthNext = rxAccept ? rxNinthVal :
        pick(rxNinth_reg, wrMask[usp_pkg::RX_NINTH_POS],
             wrVal[usp_pkg::RX_NINTH_POS]);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            modeReg_reg <= usp_pkg::CTL_RESET[usp_pkg::FRAME_WIDTH_POS];
            filterEn_reg <= usp_pkg::CTL_RESET[usp_pkg::ADDR_FILTER_POS];
            rxEnable_reg <= usp_pkg::CTL_RESET[usp_pkg::RX_ENABLE_POS];
            txNinth_reg <= usp_pkg::CTL_RESET[usp_pkg::TX_NINTH_POS];
            rxNinth_reg <= usp_pkg::CTL_RESET[usp_pkg::RX_NINTH_POS];
            txDone_reg <= usp_pkg::CTL_RESET[usp_pkg::TX_DONE_POS];
            rxDone_reg <= usp_pkg::CTL_RESET[usp_pkg::RX_DONE_POS];
        end else begin
            modeReg_reg <= pick(modeReg_reg, wrMask[usp_pkg::FRAME_WIDTH_POS],
                                wrVal[usp_pkg::FRAME_WIDTH_POS]);
            filterEn_reg <= pick(filterEn_reg,
                                 wrMask[usp_pkg::ADDR_FILTER_POS],
                                 wrVal[usp_pkg::ADDR_FILTER_POS]);
            rxEnable_reg <= pick(rxEnable_reg, wrMask[usp_pkg::RX_ENABLE_POS],
                                 wrVal[usp_pkg::RX_ENABLE_POS]);
            txNinth_reg <= pick(txNinth_reg, wrMask[usp_pkg::TX_NINTH_POS],
                                wrVal[usp_pkg::TX_NINTH_POS]);
            rxNinth_reg <= rxNinthNext;
            txDone_reg <= txDoneNext;
            rxDone_reg <= rxDoneNext;
        end
    end

    // Read data registered, one cycle after the read strobe
    wire [7:0] rdMux = ctlRd ? ctlValue : (dataRd ? rxLatch_reg : 8'h00);
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sfrRdData <= 8'h00;
        end else if (sfrRd) begin
            sfrRdData <= rdMux;
        end
    end

    assign intRequest = intEnable & (txDone_reg | rxDone_reg);

    // ------------------------------------------------------------
    // Bit-rate dividers
    // ------------------------------------------------------------
    logic txHalf_reg;
    logic rxHalf_reg;
    usp_rx_e rxState_reg;
    usp_rx_e rxState_next;
    wire txTick = timerOverflow & txHalf_reg;
    wire rxSample = timerOverflow & ~rxHalf_reg;
    wire rxFall = rxPrev_reg & ~rxPinS_reg;
    wire rxStartDet = (rxState_reg == RX_IDLE) & rxEnable_reg & rxFall;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            txHalf_reg <= 1'b0;
            rxHalf_reg <= 1'b0;
        end else begin
            txHalf_reg <= txHalf_reg ^ timerOverflow;
            // Receive divider restarts on a start edge
            rxHalf_reg <= (rxState_reg == RX_IDLE) ? 1'b0 :
                          (rxHalf_reg ^ timerOverflow);
        end
    end

    // ------------------------------------------------------------
    // Transmit buffer and shifter
    // ------------------------------------------------------------
    logic fifoOutValid;
    logic [7:0] fifoOutData;
    usp_tx_e txState_reg;
    usp_tx_e txState_next;
    logic [7:0] txShift_reg;
    logic [2:0] txCount_reg;
    wire fifoPop = (txState_reg == TX_IDLE) & txTick & fifoOutValid;

    usp_fifo #(.WIDTH(usp_pkg::DATA_BITS), .DEPTH(FIFO_DEPTH)) txFifo (
        .clk(ref_clk),
        .rstn(rstn),
        .inValid(dataWr),
        .inReady(txReady),
        .inData(sfrWrData),
        .outValid(fifoOutValid),
        .outReady(fifoPop),
        .outData(fifoOutData)
    );

    wire txLastData = txCount_reg == usp_pkg::LAST_DATA_BIT;
    assign txEnterStop = txTick & ((txState_reg == TX_NINTH) |
        ((txState_reg == TX_DATA) & txLastData & ~modeReg_reg));

    always_comb begin
        txState_next = txState_reg;
        case (txState_reg)
            TX_IDLE: txState_next = fifoPop ? TX_LOAD : TX_IDLE;
            TX_LOAD: txState_next = TX_START;
            TX_START: txState_next = txTick ? TX_DATA : TX_START;
            TX_DATA: begin
                if (txTick && txLastData) begin
                    txState_next = modeReg_reg ? TX_NINTH : TX_STOP;
                end
            end
            TX_NINTH: txState_next = txTick ? TX_STOP : TX_NINTH;
            TX_STOP: txState_next = txTick ? TX_IDLE : TX_STOP;
            default: txState_next = TX_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            txState_reg <= TX_IDLE;
            txShift_reg <= 8'h00;
            txCount_reg <= 3'h0;
            txPin <= 1'b1;
        end else begin
            txState_reg <= txState_next;
            if (txState_reg == TX_LOAD) begin
                txShift_reg <= fifoOutData;
                txPin <= 1'b0;
            end else if (txTick && (txState_reg == TX_START ||
                         (txState_reg == TX_DATA && !txLastData))) begin
                txPin <= txShift_reg[0];
                txShift_reg <= {1'b0, txShift_reg[7:1]};
                txCount_reg <= (txState_reg == TX_START) ? 3'h0 :
                               txCount_reg + 3'h1;
            end else if (txTick && txState_next == TX_NINTH) begin
                txPin <= txNinth_reg;
            end else if (txTick && txState_next == TX_STOP) begin
                txPin <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    logic [2:0] rxCount_reg;
    logic rxGotNinth_reg;
    wire rxStopSample = rxSample & (rxState_reg == RX_STOP);
    assign rxNinthVal = modeReg_reg ? rxGotNinth_reg : rxPinS_reg;
    assign rxAccept = rxStopSample & ~rxDone_reg &
                      (~filterEn_reg | rxNinthVal);

    always_comb begin
        rxState_next = rxState_reg;
        case (rxState_reg)
            RX_IDLE: rxState_next = rxStartDet ? RX_START : RX_IDLE;
            RX_START: begin
                if (rxSample) begin
                    rxState_next = rxPinS_reg ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rxSample && rxCount_reg == usp_pkg::LAST_DATA_BIT) begin
                    rxState_next = modeReg_reg ? RX_NINTH : RX_STOP;
                end
            end
            RX_NINTH: rxState_next = rxSample ? RX_STOP : RX_NINTH;
            RX_STOP: rxState_next = rxSample ? RX_IDLE : RX_STOP;
            default: rxState_next = RX_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rxState_reg <= RX_IDLE;
            rxShift_reg <= 8'h00;
            rxCount_reg <= 3'h0;
            rxGotNinth_reg <= 1'b0;
            rxLatch_reg <= 8'h00;
        end else begin
            rxState_reg <= rxState_next;
            if (rxState_reg == RX_START) begin
                rxCount_reg <= 3'h0;
            end else if (rxSample && rxState_reg == RX_DATA) begin
                rxShift_reg <= {rxPinS_reg, rxShift_reg[7:1]};
                rxCount_reg <= rxCount_reg + 3'h1;
            end
            if (rxSample && rxState_reg == RX_NINTH) begin
                rxGotNinth_reg <= rxPinS_reg;
            end
            if (rxAccept) begin
                rxLatch_reg <= rxShift_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    chk_fixed_one: assert property (ctlRd |=> sfrRdData[6])
        else $error("fixed bit read as zero");
    chk_mode_write: assert property (ctlByteWr
        |=> modeReg_reg == $past(sfrWrData[7]))
        else $error("frame width bit not written");
    chk_rx_gate: assert property (rxState_reg == RX_IDLE && !rxEnable_reg
        |=> rxState_reg == RX_IDLE)
        else $error("reception started while disabled");
    chk_filter_eight: assert property (rxStopSample && !modeReg_reg &&
        filterEn_reg && !rxPinS_reg |-> !rxAccept)
        else $error("bad stop bit accepted");
    chk_filter_nine: assert property (rxStopSample && modeReg_reg &&
        filterEn_reg && !rxGotNinth_reg |-> !rxAccept)
        else $error("data frame passed address filter");
    chk_rx_ninth: assert property (rxAccept
        |=> rxNinth_reg == $past(rxNinthVal) && rxDone_reg)
        else $error("ninth bit not captured");
    chk_rx_full: assert property (rxDone_reg && !ctlWrAny
        |=> rxDone_reg && $stable(rxLatch_reg))
        else $error("receive flag or latch changed");
    chk_tx_done: assert property (txEnterStop |=> txDone_reg ##0
        txPin)
        else $error("transmit done not set at stop");
    chk_tx_sticky: assert property (txDone_reg && !ctlWrAny
        |=> txDone_reg)
        else $error("transmit done cleared by hardware");
    chk_tx_ninth: assert property (txState_reg == TX_NINTH &&
        $past(txState_reg) == TX_DATA |-> txPin == $past(txNinth_reg))
        else $error("ninth bit level wrong");
    chk_tx_start: assert property (fifoPop |=> ##1 !txPin ##0
        txState_reg == TX_START)
        else $error("frame did not start");
    chk_tx_rate: assert property (txTick |=> !txTick [*2])
        else $error("bit ticks too close");
endmodule

// ### bench/usp_remote_uart.sv
// Remote serial partner that sends frames and captures frames
`timescale 1ns/1ps
module usp_remote_uart #(
    parameter int BIT_CYCLES = 16
) (
    input wire logic clk,
    input wire logic lineIn,
    output logic lineOut,
    input wire logic nineBit
);
    logic [9:0] got[$];
    logic [7:0] data = 8'h00;
    logic ninth = 1'b0;
    initial lineOut = 1'b1;

    // ------------------------------------------------------------
    // Sender, line idles high between frames
    // ------------------------------------------------------------
    task automatic send_frame(input logic [7:0] d, input logic nine,
                              input logic n9, input logic stopVal);
        logic [10:0] bits;
        bits = nine ? {stopVal, n9, d, 1'b0}
                    : {1'b1, stopVal, d, 1'b0};
        for (int i = 0; i < (nine ? 11 : 10); i++) begin
            @(negedge clk);
            lineOut <= bits[i];
            repeat (BIT_CYCLES - 1) @(negedge clk);
        end
        @(negedge clk);
        lineOut <= 1'b1;
        repeat (2 * BIT_CYCLES) @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // Receiver, samples each bit near its middle
    // ------------------------------------------------------------
    always begin
        @(negedge lineIn);
        repeat (BIT_CYCLES / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge clk);
            data[i] = lineIn;
        end
        ninth = 1'b0;
        if (nineBit) begin
            repeat (BIT_CYCLES) @(posedge clk);
            ninth = lineIn;
        end
        repeat (BIT_CYCLES) @(posedge clk);
        got.push_back({lineIn, ninth, data});
    end
endmodule

// ### bench/uart_serial_port_control_tb_top.sv
// Self-checking bench for the serial port control block
`timescale 1ns/1ps
module uart_serial_port_control_tb_top;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] sfrAddr = 8'h00;
    logic [3:0] sfrPage = 4'h0;
    logic sfrWr = 1'b0;
    logic sfrRd = 1'b0;
    logic [7:0] sfrWrData = 8'h00;
    logic [7:0] sfrRdData;
    logic bitWr = 1'b0;
    logic [7:0] bitAddr = 8'h00;
    logic bitWrData = 1'b0;
    logic timerOverflow = 1'b0;
    logic intEnable = 1'b0;
    logic intRequest;
    logic txReady;
    logic rxPin;
    logic txPin;
    logic nineMode = 1'b0;
    logic lastReady;
    logic [7:0] lastRx = 8'h00;
    logic [7:0] expQ[$];
    int ovfCnt = 0;
    int num_errors = 0;
    int compares = 0;

    always #2.5 ref_clk = ~ref_clk;

    // Overflow every 8 cycles, so one bit lasts 16 cycles
    always @(negedge ref_clk) begin
        ovfCnt <= (ovfCnt + 1) % 8;
        timerOverflow <= (ovfCnt == 7);
    end

    usp_serial_port dut (.ref_clk(ref_clk), .resetn(resetn),
        .sfrAddr(sfrAddr), .sfrPage(sfrPage), .sfrWr(sfrWr), .sfrRd(sfrRd),
        .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .bitWr(bitWr),
        .bitAddr(bitAddr), .bitWrData(bitWrData),
        .timerOverflow(timerOverflow), .intEnable(intEnable),
        .intRequest(intRequest), .txReady(txReady), .rxPin(rxPin),
        .txPin(txPin));

    usp_remote_uart #(.BIT_CYCLES(16)) remote (.clk(ref_clk),
        .lineIn(txPin), .lineOut(rxPin), .nineBit(nineMode));

    // ------------------------------------------------------------
    // Bus cycles and comparisons
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        lastReady = txReady;
        sfrAddr <= a;
        sfrWrData <= d;
        sfrWr <= 1'b1;
        @(negedge ref_clk);
        sfrWr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        sfrAddr <= a;
        sfrRd <= 1'b1;
        @(negedge ref_clk);
        sfrRd <= 1'b0;
        check(sfrRdData, exp);
    endtask

    task automatic bit_wr(input int n, input logic v);
        @(negedge ref_clk);
        bitAddr <= usp_pkg::CTL_ADDR + 8'(n);
        bitWrData <= v;
        bitWr <= 1'b1;
        @(negedge ref_clk);
        bitWr <= 1'b0;
    endtask

    task automatic wait_frames(input int n);
        int k;
        k = 0;
        while (remote.got.size() < n && k < 4000) begin
            @(negedge ref_clk);
            k++;
        end
        check({7'h00, remote.got.size() >= n}, 8'h01);
    endtask

    task automatic chk_frame(input logic [7:0] d, input logic [1:0] tail);
        logic [9:0] f;
        f = remote.got.pop_front();
        check(f[7:0], d);
        check({6'h00, f[9:8]}, {6'h00, tail});
    endtask

    task automatic rx_case(input logic [7:0] ctl, input logic ninth,
                           input logic stopVal, input logic [7:0] d,
                           input logic acc);
        logic nb;
        logic [7:0] exp;
        nb = ctl[7] ? ninth : stopVal;
        exp = ctl | 8'h40 | (acc ? {5'h00, nb, 2'b01} : 8'h00);
        wr(usp_pkg::CTL_ADDR, ctl);
        remote.send_frame(d, ctl[7], ninth, stopVal);
        if (acc)
            lastRx = d;
        rd_chk(usp_pkg::CTL_ADDR, exp);
        rd_chk(usp_pkg::DATA_ADDR, lastRx);
        check({7'h00, intRequest}, {7'h00, exp[0]});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd_chk(usp_pkg::CTL_ADDR, usp_pkg::CTL_RESET);
        rd_chk(8'h9A, 8'h00);
        sfrPage = 4'h1;
        wr(usp_pkg::CTL_ADDR, 8'h10);
        rd_chk(usp_pkg::CTL_ADDR, 8'h00);
        sfrPage = 4'h0;
        rd_chk(usp_pkg::CTL_ADDR, 8'h40);
        wr(usp_pkg::CTL_ADDR, 8'hBF);
        rd_chk(usp_pkg::CTL_ADDR, 8'hFF);
        intEnable = 1'b1;
        wr(usp_pkg::CTL_ADDR, 8'h02);
        repeat (50) @(negedge ref_clk);
        rd_chk(usp_pkg::CTL_ADDR, 8'h42);
        check({7'h00, intRequest}, 8'h01);
        intEnable = 1'b0;
        wr(usp_pkg::CTL_ADDR, 8'h00);
        for (int n = 0; n < 8; n++) begin
            bit_wr(n, 1'b1);
            rd_chk(usp_pkg::CTL_ADDR, 8'h40 | ((8'h02 << n) - 8'h01));
        end
        for (int n = 0; n < 8; n++)
            bit_wr(n, 1'b0);
        rd_chk(usp_pkg::CTL_ADDR, 8'h40);
    endtask

    task automatic t_tx8();
        wr(usp_pkg::CTL_ADDR, 8'h00);
        wr(usp_pkg::DATA_ADDR, 8'hA5);
        wr(usp_pkg::DATA_ADDR, 8'h3C);
        wait_frames(2);
        chk_frame(8'hA5, 2'b10);
        chk_frame(8'h3C, 2'b10);
        rd_chk(usp_pkg::CTL_ADDR, 8'h42);
    endtask

    task automatic t_fifo();
        int refused;
        refused = 0;
        wr(usp_pkg::CTL_ADDR, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(usp_pkg::DATA_ADDR, 8'h10 + 8'(i));
            if (lastReady === 1'b1)
                expQ.push_back(8'h10 + 8'(i));
            else
                refused++;
        end
        check({7'h00, refused > 0}, 8'h01);
        wait_frames(expQ.size());
        while (expQ.size() > 0)
            chk_frame(expQ.pop_front(), 2'b10);
        check({7'h00, txReady}, 8'h01);
    endtask

    task automatic t_tx9();
        nineMode = 1'b1;
        for (int v = 1; v >= 0; v--) begin
            wr(usp_pkg::CTL_ADDR, 8'h80 | 8'(v * 8));
            wr(usp_pkg::DATA_ADDR, 8'h5A);
            wait_frames(1);
            chk_frame(8'h5A, {1'b1, v[0]});
            rd_chk(usp_pkg::CTL_ADDR, 8'hC2 | 8'(v * 8));
        end
        nineMode = 1'b0;
    endtask

    task automatic t_rx();
        intEnable = 1'b1;
        rx_case(8'h00, 1'b0, 1'b1, 8'h11, 1'b0);
        rx_case(8'h10, 1'b0, 1'b1, 8'h96, 1'b1);
        rx_case(8'h11, 1'b0, 1'b1, 8'h22, 1'b0);
        rx_case(8'h30, 1'b0, 1'b0, 8'h33, 1'b0);
        rx_case(8'h30, 1'b0, 1'b1, 8'h44, 1'b1);
        rx_case(8'h10, 1'b0, 1'b0, 8'h55, 1'b1);
        rx_case(8'hB0, 1'b0, 1'b1, 8'h66, 1'b0);
        rx_case(8'hB0, 1'b1, 1'b1, 8'h77, 1'b1);
        rx_case(8'h90, 1'b0, 1'b0, 8'h88, 1'b1);
        intEnable = 1'b0;
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (3) @(negedge ref_clk);
        t_regs();
        t_tx8();
        t_fifo();
        t_tx9();
        t_rx();
        wrap_up();
    end

    // Watchdog well beyond the expected run of some 3600 cycles
    initial begin
        repeat (40000) @(posedge ref_clk);
        num_errors++;
        $display("watchdog expired at %0t", $time);
        wrap_up();
    end
endmodule
